// file: slr_pkg.sv
package slr_pkg;
  // ---------------------------------------------------------------
  // register map (index, byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [7:0] SLR_IDX_THRESHOLD = 8'h74;
  localparam logic [7:0] SLR_IDX_LOAD_RESULT_V4 = 8'h75;
  localparam logic [7:0] SLR_IDX_LOAD_FILTER_SAMPLES = 8'h76;
  localparam logic [7:0] SLR_IDX_IRQ_STATUS = 8'h78;
  localparam logic [7:0] SLR_IDX_IRQ_ENABLE = 8'h79;
  localparam logic [7:0] SLR_IDX_IRQ_CLEAR = 8'h7A;
  localparam logic [7:0] SLR_IDX_STATUS = 8'h7B;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int SLR_FILT_EN_BIT = 8;
  localparam int SLR_THR_W = 8;
  localparam int SLR_RES_W = 10;
  localparam int SLR_THR_MUL_SHIFT = 1;
  localparam logic [31:0] SLR_RESET_WORD = 32'h0000_0000;
  localparam int SLR_IRQ_STALL_BIT = 0;
  localparam int SLR_IRQ_UPDATE_BIT = 1;
  localparam int SLR_IRQ_W = 2;
endpackage : slr_pkg

// file: slr_stall_load.sv
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
module slr_stall_load (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // measurement core side
  input wire logic fullstep,
  input wire logic [slr_pkg::SLR_RES_W-1:0] meas_result,
  input wire logic [31:0] meas_samples,
  // status outputs
  output logic stall,
  output logic load_filter_enable,
  output logic irq
);
  import slr_pkg::*;

  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic acc;
  logic wr;
  logic [9:0] idx;
  logic [SLR_THR_W-1:0] stall_threshold_ff;
  logic load_filter_enable_ff;
  logic [SLR_RES_W-1:0] load_result_v4_ff;
  logic [31:0] load_filter_samples_ff;
  logic stall_ff;
  logic [SLR_IRQ_W-1:0] irq_status_ff;
  logic [SLR_IRQ_W-1:0] irq_enable_ff;
  logic [SLR_IRQ_W-1:0] nxt_irq_status;
  logic [SLR_IRQ_W-1:0] clr;
  logic stall_now;
  logic [SLR_RES_W-1:0] masked_result;
  logic [SLR_RES_W:0] thr_x2;

  // zero-wait slave; every access ends in its first access cycle
  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign idx = paddr[11:2];
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ---------------------------------------------------------------
  // threshold register
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stall_threshold_ff <= SLR_RESET_WORD[SLR_THR_W-1:0];
      load_filter_enable_ff <= 1'b0;
    end else if (wr && idx == {2'b00, SLR_IDX_THRESHOLD}) begin
      stall_threshold_ff <= pwdata[SLR_THR_W-1:0];
      load_filter_enable_ff <= pwdata[SLR_FILT_EN_BIT];
    end
  end
  assign load_filter_enable = load_filter_enable_ff;

  // ---------------------------------------------------------------
  // fullstep capture and stall compare
  // ---------------------------------------------------------------
  // force bits 9 and 0 low; 10-bit scale kept
  assign masked_result = {1'b0, meas_result[8:1], 1'b0};
  assign thr_x2 = {2'b00, stall_threshold_ff, 1'b0};
  // higher result = lighter load, so low result is a stall
  assign stall_now = {1'b0, masked_result} <= thr_x2;

  // refresh on any fullstep, no other gating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_result_v4_ff <= SLR_RESET_WORD[SLR_RES_W-1:0];
      stall_ff <= 1'b0;
    end else if (fullstep) begin
      load_result_v4_ff <= masked_result;
      stall_ff <= stall_now;
    end
  end
  assign stall = stall_ff;

  // raw samples captured while the filter is enabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      load_filter_samples_ff <= SLR_RESET_WORD;
    end else if (fullstep && load_filter_enable_ff) begin
      load_filter_samples_ff <= meas_samples;
    end
  end

  // ---------------------------------------------------------------
  // interrupts
  // ---------------------------------------------------------------
  assign clr = (wr && idx == {2'b00, SLR_IDX_IRQ_CLEAR}) ? pwdata[SLR_IRQ_W-1:0] : '0;
  // set wins over clear in the same cycle
  always_comb begin
    nxt_irq_status = irq_status_ff & ~clr;
    nxt_irq_status[SLR_IRQ_STALL_BIT] = nxt_irq_status[SLR_IRQ_STALL_BIT] |
      (fullstep & stall_now);
    nxt_irq_status[SLR_IRQ_UPDATE_BIT] = nxt_irq_status[SLR_IRQ_UPDATE_BIT] | fullstep;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_ff <= '0;
    end else begin
      irq_status_ff <= nxt_irq_status;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_ff <= '0;
    end else if (wr && idx == {2'b00, SLR_IDX_IRQ_ENABLE}) begin
      irq_enable_ff <= pwdata[SLR_IRQ_W-1:0];
    end
  end
  assign irq = |(irq_status_ff & irq_enable_ff);

  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    prdata = 32'h0000_0000;
    if (acc && !pwrite) begin
      unique case (idx)
        {2'b00, SLR_IDX_THRESHOLD}:
          prdata = {23'h00_0000, load_filter_enable_ff, stall_threshold_ff};
        {2'b00, SLR_IDX_LOAD_RESULT_V4}: prdata = {22'h00_0000, load_result_v4_ff};
        {2'b00, SLR_IDX_LOAD_FILTER_SAMPLES}: prdata = load_filter_samples_ff;
        {2'b00, SLR_IDX_IRQ_STATUS}: prdata = {30'h0000_0000, irq_status_ff};
        {2'b00, SLR_IDX_IRQ_ENABLE}: prdata = {30'h0000_0000, irq_enable_ff};
        {2'b00, SLR_IDX_STATUS}: prdata = {31'h0000_0000, stall_ff};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_stall_cmp;
    @(posedge pclk) disable iff (!presetn)
    fullstep |=> stall == ({1'b0, load_result_v4_ff} <= {2'b00, $past(stall_threshold_ff), 1'b0});
  endproperty
  a_stall_cmp: assert property (p_stall_cmp) else $error("stall compare wrong");

  property p_refresh;
    @(posedge pclk) disable iff (!presetn)
    fullstep |=> load_result_v4_ff[8:1] == $past(meas_result[8:1]);
  endproperty
  a_refresh: assert property (p_refresh) else $error("result not refreshed");

  property p_hold;
    @(posedge pclk) disable iff (!presetn)
    !fullstep |=> $stable(load_result_v4_ff) && $stable(stall);
  endproperty
  a_hold: assert property (p_hold) else $error("result changed off fullstep");

  property p_ind_thr;
    @(posedge pclk) disable iff (!presetn)
    fullstep && stall_threshold_ff == 8'hFF |=> stall;
  endproperty
  a_ind_thr: assert property (p_ind_thr) else $error("refresh gated by threshold");

  property p_zero_bits;
    @(posedge pclk) disable iff (!presetn)
    load_result_v4_ff[9] == 1'b0 && load_result_v4_ff[0] == 1'b0;
  endproperty
  a_zero_bits: assert property (p_zero_bits) else $error("result edge bits set");

  property p_samples;
    @(posedge pclk) disable iff (!presetn)
    fullstep && load_filter_enable_ff |=> load_filter_samples_ff == $past(meas_samples);
  endproperty
  a_samples: assert property (p_samples) else $error("samples not captured");

  property p_byte0;
    @(posedge pclk) disable iff (!presetn)
    acc && !pwrite && idx == {2'b00, SLR_IDX_LOAD_FILTER_SAMPLES}
      |-> prdata[7:0] == load_filter_samples_ff[7:0];
  endproperty
  a_byte0: assert property (p_byte0) else $error("byte zero misplaced");

  property p_filt_en;
    @(posedge pclk) disable iff (!presetn)
    wr && idx == {2'b00, SLR_IDX_THRESHOLD} |=> load_filter_enable == $past(pwdata[8]);
  endproperty
  a_filt_en: assert property (p_filt_en) else $error("filter enable not written");

  property p_thr;
    @(posedge pclk) disable iff (!presetn)
    wr && idx == {2'b00, SLR_IDX_THRESHOLD} |=> stall_threshold_ff == $past(pwdata[7:0]);
  endproperty
  a_thr: assert property (p_thr) else $error("threshold not written");

  // ---------------------------------------------------------------
  // named steps shared by the checks below
  // ---------------------------------------------------------------
  sequence s_step;
    fullstep;
  endsequence

  sequence s_result_read;
    acc && !pwrite && idx == {2'b00, SLR_IDX_LOAD_RESULT_V4};
  endsequence

  sequence s_samples_read;
    acc && !pwrite && idx == {2'b00, SLR_IDX_LOAD_FILTER_SAMPLES};
  endsequence

  sequence s_clear_only;
    wr && idx == {2'b00, SLR_IDX_IRQ_CLEAR} && !fullstep;
  endsequence

  sequence s_enable_write;
    wr && idx == {2'b00, SLR_IDX_IRQ_ENABLE};
  endsequence

  // release of reset finds result, samples and stall cleared
  property p_reset_zero;
    @(posedge pclk) disable iff (!presetn)
    $rose(presetn) |-> load_result_v4_ff == '0 && load_filter_samples_ff == '0 && !stall;
  endproperty
  a_reset_zero: assert property (p_reset_zero) else $error("state not zero after reset");

  // result word on the bus: upper bits and edge bits low
  property p_result_bus;
    @(posedge pclk) disable iff (!presetn)
    s_result_read |-> prdata[31:10] == 22'h00_0000 && !prdata[9] && !prdata[0];
  endproperty
  a_result_bus: assert property (p_result_bus) else $error("result read edge bits set");

  // samples only move on a fullstep with the filter on
  property p_samples_hold;
    @(posedge pclk) disable iff (!presetn)
    !(fullstep && load_filter_enable_ff) |=> $stable(load_filter_samples_ff);
  endproperty
  a_samples_hold: assert property (p_samples_hold) else $error("samples moved uncaptured");

  property p_samples_bus;
    @(posedge pclk) disable iff (!presetn)
    s_samples_read |-> prdata[31:8] == load_filter_samples_ff[31:8];
  endproperty
  a_samples_bus: assert property (p_samples_bus) else $error("sample bytes misplaced");

  // threshold fields only change on their own write
  property p_thr_hold;
    @(posedge pclk) disable iff (!presetn)
    !(wr && idx == {2'b00, SLR_IDX_THRESHOLD})
      |=> $stable(stall_threshold_ff) && $stable(load_filter_enable_ff);
  endproperty
  a_thr_hold: assert property (p_thr_hold) else $error("threshold moved unwritten");

  // full-scale result is light load, never a stall below top threshold
  property p_stall_light;
    @(posedge pclk) disable iff (!presetn)
    s_step ##0 (meas_result[8:1] == 8'hFF && stall_threshold_ff != 8'hFF) |=> !stall;
  endproperty
  a_stall_light: assert property (p_stall_light) else $error("light load flagged stall");

  // zero result is heaviest load, always a stall
  property p_stall_heavy;
    @(posedge pclk) disable iff (!presetn)
    s_step ##0 (meas_result[8:1] == 8'h00) |=> stall;
  endproperty
  a_stall_heavy: assert property (p_stall_heavy) else $error("heavy load not flagged");

  // event bits set on their fullstep, clear or not
  property p_stall_flag;
    @(posedge pclk) disable iff (!presetn)
    s_step ##0 stall_now |=> irq_status_ff[SLR_IRQ_STALL_BIT];
  endproperty
  a_stall_flag: assert property (p_stall_flag) else $error("stall event lost");

  property p_update_flag;
    @(posedge pclk) disable iff (!presetn)
    s_step |=> irq_status_ff[SLR_IRQ_UPDATE_BIT];
  endproperty
  a_update_flag: assert property (p_update_flag) else $error("refresh event lost");

  // clear without a competing event drops the written bits
  property p_irq_clear;
    @(posedge pclk) disable iff (!presetn)
    s_clear_only |=> (irq_status_ff & $past(pwdata[SLR_IRQ_W-1:0])) == '0;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("status not cleared");

  property p_enable_write;
    @(posedge pclk) disable iff (!presetn)
    s_enable_write |=> irq_enable_ff == $past(pwdata[SLR_IRQ_W-1:0]);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable not written");

  // read data only driven during a read access
  property p_prdata_idle;
    @(posedge pclk) disable iff (!presetn)
    !(acc && !pwrite) |-> prdata == 32'h0000_0000;
  endproperty
  a_prdata_idle: assert property (p_prdata_idle) else $error("read data outside read access");
endmodule : slr_stall_load

// file: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import slr_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and block under test
  // ----------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, fullstep;
  logic stall, load_filter_enable, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, meas_samples, rd;
  logic [9:0] meas_result;
  int errors = 0;
  int checks_done = 0;
  int cyc = 0;
  slr_stall_load slr_stall_load_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .fullstep(fullstep), .meas_result(meas_result),
    .meas_samples(meas_samples), .stall(stall), .load_filter_enable(load_filter_enable),
    .irq(irq));
  // 50 MHz clock
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  // cycle ceiling against hangs
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      errors = errors + 1;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks_done = checks_done + 1;
    if (s !== e) begin
      errors = errors + 1;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask : apb
  task automatic rdchk(input string nm, input logic [7:0] idx, input logic [31:0] e);
    apb(1'b0, idx, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rdchk
  // one-cycle fullstep pulse; inputs scrambled afterwards
  task automatic step(input logic [9:0] r, input logic [31:0] s);
    @(posedge pclk);
    fullstep <= 1'b1;
    meas_result <= r;
    meas_samples <= s;
    @(posedge pclk);
    fullstep <= 1'b0;
    meas_result <= ~r;
    meas_samples <= ~s;
  endtask : step
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdchk("result", SLR_IDX_LOAD_RESULT_V4, SLR_RESET_WORD);
    rdchk("samples", SLR_IDX_LOAD_FILTER_SAMPLES, SLR_RESET_WORD);
    chk("stall", 32'h0000_0000, 32'(stall));
    $display("test reset done");
  endtask : t_reset
  task automatic t_samp();
    apb(1'b1, SLR_IDX_THRESHOLD, 32'h0000_0100);
    chk("filter_en", 32'h0000_0001, 32'(load_filter_enable));
    step(10'h100, 32'hA1B2_C3D4);
    rdchk("samples", SLR_IDX_LOAD_FILTER_SAMPLES, 32'hA1B2_C3D4);
    apb(1'b1, SLR_IDX_THRESHOLD, 32'h0000_0000);
    chk("filter_en", 32'h0000_0000, 32'(load_filter_enable));
    step(10'h104, 32'h5566_7788);
    rdchk("samples", SLR_IDX_LOAD_FILTER_SAMPLES, 32'hA1B2_C3D4);
    rdchk("result", SLR_IDX_LOAD_RESULT_V4, 32'h0000_0104);
    $display("test samples done");
  endtask : t_samp
  // boundaries of the doubled threshold, with bits 9 and 0 forced low
  task automatic t_stall();
    logic [7:0] th [3] = '{8'h40, 8'hFF, 8'h00};
    logic [9:0] rs [5] = '{10'h080, 10'h082, 10'h081, 10'h3FF, 10'h200};
    logic [9:0] m;
    foreach (th[i]) begin
      apb(1'b1, SLR_IDX_THRESHOLD, {23'h00_0000, 1'b1, th[i]});
      rdchk("threshold", SLR_IDX_THRESHOLD, {23'h00_0000, 1'b1, th[i]});
      foreach (rs[j]) begin
        step(rs[j], 32'h0000_0000);
        m = rs[j] & 10'h1FE;
        rdchk("result", SLR_IDX_LOAD_RESULT_V4, 32'(m));
        chk("stall", 32'(m <= {th[i], 1'b0}), 32'(stall));
        rdchk("stall_reg", SLR_IDX_STATUS, 32'(m <= {th[i], 1'b0}));
      end
    end
    $display("test stall done");
  endtask : t_stall
  task automatic t_irq();
    apb(1'b1, SLR_IDX_IRQ_ENABLE, 32'h0000_0000);
    apb(1'b1, SLR_IDX_IRQ_CLEAR, 32'h0000_0003);
    apb(1'b1, SLR_IDX_THRESHOLD, 32'h0000_0010);
    step(10'h010, 32'h0000_0000);
    rdchk("irq_status", SLR_IDX_IRQ_STATUS, 32'h0000_0003);
    chk("irq_masked", 32'h0000_0000, 32'(irq));
    apb(1'b1, SLR_IDX_IRQ_ENABLE, 32'h0000_0001);
    rdchk("irq_enable", SLR_IDX_IRQ_ENABLE, 32'h0000_0001);
    chk("irq_on", 32'h0000_0001, 32'(irq));
    apb(1'b1, SLR_IDX_IRQ_CLEAR, 32'h0000_0001);
    rdchk("irq_status", SLR_IDX_IRQ_STATUS, 32'h0000_0002);
    chk("irq_cleared", 32'h0000_0000, 32'(irq));
    apb(1'b1, SLR_IDX_IRQ_ENABLE, 32'h0000_0002);
    chk("irq_update", 32'h0000_0001, 32'(irq));
    apb(1'b1, SLR_IDX_IRQ_CLEAR, 32'h0000_0002);
    chk("irq_off", 32'h0000_0000, 32'(irq));
    $display("test irq done");
  endtask : t_irq
  task automatic t_map();
    rdchk("unmapped", 8'h77, 32'h0000_0000);
    apb(1'b1, SLR_IDX_LOAD_RESULT_V4, 32'hFFFF_FFFF);
    rdchk("result_ro", SLR_IDX_LOAD_RESULT_V4, 32'h0000_0010);
    chk("pslverr", 32'h0000_0000, 32'(pslverr));
    chk("pready", 32'h0000_0001, 32'(pready));
    $display("test map done");
  endtask : t_map
  // reset in mid-run clears what earlier tests left behind
  task automatic t_rerun();
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    chk("stall", 32'h0000_0000, 32'(stall));
    rdchk("result", SLR_IDX_LOAD_RESULT_V4, SLR_RESET_WORD);
    rdchk("samples", SLR_IDX_LOAD_FILTER_SAMPLES, SLR_RESET_WORD);
    $display("test rerun done");
  endtask : t_rerun
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, fullstep} = 5'h00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    meas_result = 10'h000;
    meas_samples = 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_samp();
    t_stall();
    t_irq();
    t_map();
    t_rerun();
    close_out();
  end
endmodule : tb_top
